// ==== logic/srp_port.sv ====
// Behaviour
// - Answer one of eight I2C addresses chosen by the two straps.
// - Each strap reads as VCC, GND, SCL or SDA; two ties per address.
// - Bit 0 of the I2C address byte selects read or write.
// - Sub-address bits 6:3 name the register; bit 7 reserved.
// - Four-wire SPI port, serial rate up to 5 Mbps.
// - Bit 7 of the SPI command byte: one reads, zero writes.
// - SPI command bits 6:3 register, 2:1 channel zero, 0 reserved.
// - One SPI burst may fill the TX FIFO or drain the RX FIFO.
// - Reset returns registers and the I2C data output to defaults; SPI frame state and SPI output clear only with chip select high.
// - FIFO on, no RS-485: TX interrupt high while above trigger level.
// - RS-485 mode: TX interrupt falls when transmitter is empty, or with FIFO on below trigger.
// - FIFO off: RX interrupt low once one byte is received.
// - FIFO on: RX interrupt low while RX FIFO is above trigger.
// - Serial access timed by host clock, not the UART clock.
// - Interface-select pin chooses I2C or SPI.
// - I2C acks each written byte, nacks a write to a full TX FIFO.
module srp_port
  import srp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       link_scl,
  input  wire logic       if_sel_i2c,
  input  wire logic       addr_strap_lo,
  input  wire logic       addr_strap_hi,
  input  wire logic       i2c_sda_i,
  output logic            i2c_sda_o,
  output logic            i2c_sda_oe,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_si,
  output logic            spi_so,
  output logic            spi_so_oe,
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       tx_fifo_full,
  input  wire logic       fifo_en,
  input  wire logic       rs485_en,
  input  wire logic       thr_full,
  input  wire logic       tx_above_trig,
  input  wire logic       tx_all_empty,
  input  wire logic       rx_avail,
  input  wire logic       rx_above_trig,
  output logic            irq_tx_n,
  output logic            irq_rx_n,
  output logic            irq_n
);

  logic [SYNC_W-1:0] sync_d;
  logic [SYNC_W-1:0] sync_q;
  logic              scl_s;
  logic              sda_s;
  logic              mode_i2c;
  logic              tog_s;
  logic [7:0]        rdbuf_q;
  logic [7:0]        rdbuf_d;
  logic              ltog_q;
  logic              ltog_d;

  // ==========================================================================
  // Pin synchronisers
  // The link toggle crosses here too; its data words stay still meanwhile.
  assign sync_d = {ltog_q, if_sel_i2c, addr_strap_hi, addr_strap_lo,
                   i2c_sda_i, link_scl};

  srp_sync #(.W(SYNC_W)) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .d        (sync_d),
    .q        (sync_q)
  );

  assign scl_s    = sync_q[SY_SCL];
  assign sda_s    = sync_q[SY_SDA];
  assign mode_i2c = sync_q[SY_IF_I2C];
  assign tog_s    = sync_q[SY_TOG];

  // ==========================================================================
  // SPI link side, clocked by the host's serial clock
  // Frame state clears while chip select is high, so a stopped clock is fine.
  logic [2:0] lcnt_q;
  logic [2:0] lcnt_d;
  logic       lfirst_q;
  logic       lfirst_d;
  logic [7:0] lsh_q;
  logic [7:0] lsh_d;
  logic [7:0] lcmd_q;
  logic [7:0] lcmd_d;
  logic [7:0] ldata_q;
  logic [7:0] ldata_d;
  logic [7:0] so_sh_q;
  logic [7:0] so_sh_d;
  logic       so_oe_q;
  logic       so_oe_d;

  // Bit counter and input shifter
  always_comb begin
    lsh_d    = {lsh_q[6:0], spi_si};
    lcnt_d   = lcnt_q + 3'h1;
    lfirst_d = lfirst_q | (lcnt_q == SPI_LAST);
  end

  always_ff @(posedge link_scl or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      lcnt_q   <= 3'h0;
      lfirst_q <= 1'b0;
      lsh_q    <= 8'h00;
    end else begin
      lcnt_q   <= lcnt_d;
      lfirst_q <= lfirst_d;
      lsh_q    <= lsh_d;
    end
  end

  // Command, data and event toggle; kept past chip select for the core
  always_comb begin
    lcmd_d  = lcmd_q;
    ldata_d = ldata_q;
    ltog_d  = ltog_q;
    if (!lfirst_q && lcnt_q == SPI_PREF) begin
      // Direction and address are known after five bits
      lcmd_d = {lsh_d[4:0], 3'h0};
      if (lsh_d[4]) begin
        ltog_d = !ltog_q;
      end
    end
    if (!lfirst_q && lcnt_q == SPI_LAST) begin
      lcmd_d[2:0] = lsh_d[2:0];
    end
    if (lfirst_q && lcnt_q == SPI_LAST) begin
      ldata_d = lsh_d;
      if (!lcmd_q[CMD_RW_BIT]) begin
        ltog_d = !ltog_q;
      end
    end
    // Fetch the next read byte while this one still shifts out
    if (lfirst_q && lcmd_q[CMD_RW_BIT] && lcnt_q == SPI_PREF) begin
      ltog_d = !ltog_q;
    end
  end

  always_ff @(posedge link_scl or posedge sys_rst) begin
    if (sys_rst) begin
      lcmd_q  <= 8'h00;
      ldata_q <= 8'h00;
      ltog_q  <= 1'b0;
    end else begin
      lcmd_q  <= lcmd_d;
      ldata_q <= ldata_d;
      ltog_q  <= ltog_d;
    end
  end

  // Output shifter on the falling edge; rdbuf is held still by handshake
  always_comb begin
    so_sh_d = so_sh_q;
    so_oe_d = 1'b0;
    if (lfirst_q && lcmd_q[CMD_RW_BIT]) begin
      so_oe_d = 1'b1;
      if (lcnt_q == 3'h0) begin
        so_sh_d = rdbuf_q;
      end else begin
        so_sh_d = {so_sh_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(negedge link_scl or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      so_sh_q <= 8'h00;
      so_oe_q <= 1'b0;
    end else begin
      so_sh_q <= so_sh_d;
      so_oe_q <= so_oe_d;
    end
  end

  assign spi_so    = so_sh_q[7];
  assign spi_so_oe = so_oe_q;

  // ==========================================================================
  // Strap decoding
  // A strap is ruled out of a level once it is seen to differ from it.
  logic [1:0] strap_s;
  logic [1:0] strap_code [2];
  logic [6:0] my_addr;
  logic [1:0] settle_q;
  logic [1:0] settle_d;

  assign strap_s = {sync_q[SY_STRAP_HI], sync_q[SY_STRAP_LO]};

  // Skip the cycles while the synchronisers still hold reset zeros
  always_comb begin
    settle_d = settle_q;
    if (settle_q != STRAP_SETTLE) begin
      settle_d = settle_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      settle_q <= 2'h0;
    end else begin
      settle_q <= settle_d;
    end
  end

  genvar g;
  for (g = 0; g < 2; g++) begin : g_strap
    logic [3:0] seen_q;
    logic [3:0] seen_d;

    always_comb begin
      seen_d = seen_q;
      if (settle_q == STRAP_SETTLE) begin
        seen_d = seen_q | {strap_s[g] ^ sda_s, strap_s[g] ^ scl_s,
                           strap_s[g], !strap_s[g]};
      end
    end

    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        seen_q <= 4'h0;
      end else begin
        seen_q <= seen_d;
      end
    end

    assign strap_code[g] = !seen_q[0] ? STRAP_VCC :
                           !seen_q[1] ? STRAP_GND :
                           !seen_q[2] ? STRAP_SCL : STRAP_SDA;
  end

  assign my_addr = {I2C_ADDR_HI, strap_code[0][0], strap_code[1]};

  // ==========================================================================
  // I2C slave, oversampled on the core clock
  srp_i2c_state_e ist_q;
  srp_i2c_state_e ist_d;
  logic [7:0]     ish_q;
  logic [7:0]     ish_d;
  logic [3:0]     icnt_q;
  logic [3:0]     icnt_d;
  logic           irw_q;
  logic           irw_d;
  logic [7:0]     isub_q;
  logic [7:0]     isub_d;
  logic           ioe_q;
  logic           ioe_d;
  logic           scl_p_q;
  logic           sda_p_q;
  logic           i_wr;
  logic           i_rd;
  logic           scl_rise;
  logic           scl_fall;
  logic           i_start;
  logic           i_stop;

  assign scl_rise = scl_s & !scl_p_q;
  assign scl_fall = !scl_s & scl_p_q;
  assign i_start  = scl_s & scl_p_q & sda_p_q & !sda_s;
  assign i_stop   = scl_s & scl_p_q & !sda_p_q & sda_s;

  // Byte, acknowledge and data phases
  always_comb begin
    ist_d  = ist_q;
    ish_d  = ish_q;
    icnt_d = icnt_q;
    irw_d  = irw_q;
    isub_d = isub_q;
    ioe_d  = ioe_q;
    i_wr   = 1'b0;
    i_rd   = 1'b0;
    if (!mode_i2c) begin
      ist_d = I2C_IDLE;
      ioe_d = 1'b0;
    end else if (i_start) begin
      ist_d  = I2C_ADDR;
      icnt_d = 4'h0;
      ioe_d  = 1'b0;
    end else if (i_stop) begin
      ist_d = I2C_IDLE;
      ioe_d = 1'b0;
    end else begin
      case (ist_q)
        I2C_ADDR, I2C_SUB, I2C_WR: begin
          if (scl_rise) begin
            ish_d  = {ish_q[6:0], sda_s};
            icnt_d = icnt_q + 4'h1;
          end else if (scl_fall && icnt_q == I2C_BITS) begin
            icnt_d = 4'h0;
            ioe_d  = 1'b1;
            if (ist_q == I2C_ADDR) begin
              if (ish_q[7:1] == my_addr) begin
                irw_d = ish_q[RW_BIT];
                i_rd  = ish_q[RW_BIT];
                ist_d = I2C_ACK_A;
              end else begin
                ioe_d = 1'b0;
                ist_d = I2C_IDLE;
              end
            end else if (ist_q == I2C_SUB) begin
              isub_d = ish_q;
              ist_d  = I2C_ACK_S;
            end else begin
              i_wr  = 1'b1;
              ioe_d = !(isub_q[REG_HI:REG_LO] == REG_TX_HOLD
                        && tx_fifo_full);
              ist_d = I2C_ACK_W;
            end
          end
        end
        I2C_ACK_S, I2C_ACK_W: begin
          if (scl_fall) begin
            ioe_d = 1'b0;
            ist_d = I2C_WR;
          end
        end
        I2C_RD: begin
          if (scl_fall) begin
            if (icnt_q == I2C_BITS) begin
              ioe_d  = 1'b0;
              icnt_d = 4'h0;
              ist_d  = I2C_ACK_R;
            end else begin
              ioe_d  = !ish_q[6];
              ish_d  = {ish_q[6:0], 1'b0};
              icnt_d = icnt_q + 4'h1;
            end
          end
        end
        I2C_ACK_A, I2C_ACK_R: begin
          // Host nack ends the read; its ack fetches one more byte
          if (ist_q == I2C_ACK_R && scl_rise) begin
            if (sda_s) begin
              ist_d = I2C_IDLE;
            end else begin
              i_rd = 1'b1;
            end
          end else if (scl_fall) begin
            if (ist_q == I2C_ACK_A && !irw_q) begin
              ioe_d = 1'b0;
              ist_d = I2C_SUB;
            end else begin
              ish_d  = rdbuf_q;
              ioe_d  = !rdbuf_q[7];
              icnt_d = 4'h1;
              ist_d  = I2C_RD;
            end
          end
        end
        default: begin
          ioe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ist_q   <= I2C_IDLE;
      ish_q   <= 8'h00;
      icnt_q  <= 4'h0;
      irw_q   <= 1'b0;
      isub_q  <= 8'h00;
      ioe_q   <= 1'b0;
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
    end else begin
      ist_q   <= ist_d;
      ish_q   <= ish_d;
      icnt_q  <= icnt_d;
      irw_q   <= irw_d;
      isub_q  <= isub_d;
      ioe_q   <= ioe_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Open-drain: only ever pulls low
  assign i2c_sda_o  = 1'b0;
  assign i2c_sda_oe = ioe_q;

  // ==========================================================================
  // Register access port shared by both protocols
  logic       tog_p_q;
  logic       spi_ev;
  logic [3:0] addr_q;
  logic [3:0] addr_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic       wr_q;
  logic       wr_d;
  logic       rd_q;
  logic       rd_d;

  // A non-zero channel makes an SPI write a no-op
  assign spi_ev = !mode_i2c & (tog_s ^ tog_p_q);

  always_comb begin
    addr_d  = mode_i2c ? isub_q[REG_HI:REG_LO] : lcmd_q[REG_HI:REG_LO];
    wdata_d = mode_i2c ? ish_q : ldata_q;
    wr_d    = i_wr | (spi_ev & !lcmd_q[CMD_RW_BIT]
                      & lcmd_q[CHAN_HI:CHAN_LO] == CHAN_A);
    rd_d    = i_rd | (spi_ev & lcmd_q[CMD_RW_BIT]);
    rdbuf_d = rd_q ? reg_rdata : rdbuf_q;
  end

  // Clocked by the core clock, never by the UART baud clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tog_p_q <= 1'b0;
      addr_q  <= 4'h0;
      wdata_q <= 8'h00;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      rdbuf_q <= 8'h00;
    end else begin
      tog_p_q <= tog_s;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      rdbuf_q <= rdbuf_d;
    end
  end

  assign reg_addr  = addr_q;
  assign reg_wdata = wdata_q;
  assign reg_wr    = wr_q;
  assign reg_rd    = rd_q;

  // ==========================================================================
  // Interrupt pin
  srp_irq u_irq (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .fifo_en       (fifo_en),
    .rs485_en      (rs485_en),
    .thr_full      (thr_full),
    .tx_above_trig (tx_above_trig),
    .tx_all_empty  (tx_all_empty),
    .rx_avail      (rx_avail),
    .rx_above_trig (rx_above_trig),
    .irq_tx_n      (irq_tx_n),
    .irq_rx_n      (irq_rx_n),
    .irq_n         (irq_n)
  );

endmodule

// ==== inc/srp_pkg.sv ====
package srp_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CORE_CLK_HZ = 10_000_000;
  localparam int CORE_CLK_NS = 1_000_000_000 / CORE_CLK_HZ;
  // Least reset pulse, rounded up to whole core cycles
  localparam int RST_MIN_NS  = 40;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  // Highest serial rate of the four-wire port, bits per second
  localparam int SPI_MAX_BPS = 5_000_000;
  // FIFO depth that one burst may fill or drain
  localparam int FIFO_DEPTH  = 64;

  // ==========================================================================
  // Address and command byte layout
  localparam int RW_BIT      = 0;
  localparam int CMD_RW_BIT  = 7;
  localparam int REG_HI      = 6;
  localparam int REG_LO      = 3;
  localparam int CHAN_HI     = 2;
  localparam int CHAN_LO     = 1;
  localparam logic [1:0] CHAN_A      = 2'h0;
  localparam logic [3:0] REG_TX_HOLD = 4'h0;
  localparam logic [3:0] I2C_ADDR_HI = 4'h6;
  localparam logic [3:0] I2C_BITS    = 4'h8;
  localparam logic [2:0] SPI_LAST    = 3'h7;
  localparam logic [2:0] SPI_PREF    = 3'h4;

  // ==========================================================================
  // Strap levels, in order of test
  localparam logic [1:0] STRAP_VCC    = 2'h0;
  localparam logic [1:0] STRAP_GND    = 2'h1;
  localparam logic [1:0] STRAP_SCL    = 2'h2;
  localparam logic [1:0] STRAP_SDA    = 2'h3;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ==========================================================================
  // Synchroniser bit positions
  localparam int SYNC_W      = 6;
  localparam int SY_SCL      = 0;
  localparam int SY_SDA      = 1;
  localparam int SY_STRAP_LO = 2;
  localparam int SY_STRAP_HI = 3;
  localparam int SY_IF_I2C   = 4;
  localparam int SY_TOG      = 5;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_SUB, I2C_ACK_S,
    I2C_WR, I2C_ACK_W, I2C_RD, I2C_ACK_R
  } srp_i2c_state_e;

endpackage

// ==== logic/srp_sync.sv ====
module srp_sync
  import srp_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ==========================================================================
  // Two flops per bit; only the second stage leaves this module
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // Next values
    always_comb begin
      meta_d = d[g];
      sync_d = meta_q;
    end

    // Register stage
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= meta_d;
        sync_q <= sync_d;
      end
    end

    assign q[g] = sync_q;
  end

endmodule

// ==== logic/srp_irq.sv ====
module srp_irq
  import srp_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic fifo_en,
  input  wire logic rs485_en,
  input  wire logic thr_full,
  input  wire logic tx_above_trig,
  input  wire logic tx_all_empty,
  input  wire logic rx_avail,
  input  wire logic rx_above_trig,
  output logic      irq_tx_n,
  output logic      irq_rx_n,
  output logic      irq_n
);

  logic tx_n_q;
  logic tx_n_d;
  logic rx_n_q;
  logic rx_n_d;
  logic all_n_q;
  logic all_n_d;

  // ==========================================================================
  // Interrupt levels, all active low
  always_comb begin
    if (rs485_en) begin
      // Trigger level still rules; empty now means the whole shifter
      tx_n_d = !tx_all_empty & (tx_above_trig | !fifo_en);
    end else if (fifo_en) begin
      tx_n_d = tx_above_trig;
    end else begin
      tx_n_d = thr_full;
    end
    if (fifo_en) begin
      rx_n_d = !rx_above_trig;
    end else begin
      rx_n_d = !rx_avail;
    end
    // Either source pulls the shared pin low
    all_n_d = tx_n_d & rx_n_d;
  end

  // Idle high after reset, like an undriven pin with pull-up
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_n_q  <= 1'b1;
      rx_n_q  <= 1'b1;
      all_n_q <= 1'b1;
    end else begin
      tx_n_q  <= tx_n_d;
      rx_n_q  <= rx_n_d;
      all_n_q <= all_n_d;
    end
  end

  assign irq_tx_n = tx_n_q;
  assign irq_rx_n = rx_n_q;
  assign irq_n    = all_n_q;

endmodule

// ==== testbench/srp_port_monitor.sv ====
module srp_port_monitor (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       link_scl,
  input wire logic       if_sel_i2c,
  input wire logic       spi_cs_n,
  input wire logic       spi_so_oe,
  input wire logic       i2c_sda_oe,
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic       fifo_en,
  input wire logic       rs485_en,
  input wire logic       thr_full,
  input wire logic       tx_above_trig,
  input wire logic       tx_all_empty,
  input wire logic       rx_avail,
  input wire logic       rx_above_trig,
  input wire logic       irq_tx_n,
  input wire logic       irq_rx_n,
  input wire logic       irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tx_exp;
  logic rx_exp;

  // ==========================================================
  // Interrupt levels expected from the core flags
  assign tx_exp = rs485_en ? !tx_all_empty && (tx_above_trig || !fifo_en)
                           : (fifo_en ? tx_above_trig : thr_full);
  assign rx_exp = fifo_en ? !rx_above_trig : !rx_avail;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Checks
  irq_and_a: assert property (irq_n == (irq_tx_n && irq_rx_n))
    else $error("combined interrupt differs from its sources");
  irq_tx_a: assert property (!$past(sys_rst) |->
    irq_tx_n == $past(tx_exp))
    else $error("transmit interrupt level wrong");
  irq_rx_a: assert property (!$past(sys_rst) |->
    irq_rx_n == $past(rx_exp))
    else $error("receive interrupt level wrong");
  rst_idle_a: assert property ($fell(sys_rst) |->
    !reg_wr && !reg_rd && !i2c_sda_oe && irq_n && reg_addr == 4'h0)
    else $error("outputs not at defaults after reset");
  wr_pulse_a: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");
  rd_pulse_a: assert property (reg_rd |=> !reg_rd)
    else $error("read strobe longer than one cycle");
  so_hiz_a: assert property (spi_cs_n |-> !spi_so_oe)
    else $error("data out driven while deselected");
  sda_spi_a: assert property (!if_sel_i2c && !$past(if_sel_i2c, 4)
    |-> !i2c_sda_oe)
    else $error("data line pulled in four-wire mode");
  ack_hold_a: assert property ($rose(i2c_sda_oe) |->
    !link_scl ##1 i2c_sda_oe [*4])
    else $error("acknowledge not held through the clock low");

  // Main scenarios reached
  cover property (reg_wr);
  cover property (reg_rd);
  cover property ($rose(i2c_sda_oe));
endmodule

bind srp_port srp_port_monitor mon_u (.core_clk, .sys_rst, .link_scl,
  .if_sel_i2c, .spi_cs_n, .spi_so_oe, .i2c_sda_oe, .reg_addr, .reg_wr,
  .reg_rd, .fifo_en, .rs485_en, .thr_full, .tx_above_trig, .tx_all_empty,
  .rx_avail, .rx_above_trig, .irq_tx_n, .irq_rx_n, .irq_n);

// ==== testbench/srp_host.sv ====
module srp_host (
  input  wire logic lclk,
  input  wire logic spi_so,
  input  wire logic sda,
  output logic      link_scl,
  output logic      spi_cs_n,
  output logic      spi_si,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] i2c_rx; // Levels seen, last one the ack slot

  // ==========================================================
  // Host master; four-wire idle is clock low, select high
  initial begin
    link_scl = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
    sda_low = 1'b0;
  end

  // Select before any clock edge
  task automatic cs_lo();
    @(posedge lclk) spi_cs_n <= 1'b0;
  endtask

  // Park clock low, deselect, scramble the released data line
  task automatic cs_hi();
    @(posedge lclk) link_scl <= 1'b0;
    @(posedge lclk) spi_cs_n <= 1'b1;
    spi_si <= !spi_si;
    @(posedge lclk);
  endtask

  // Mode 0; two link cycles a bit keeps the rate at 4 Mbps
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge lclk) link_scl <= 1'b0;
      spi_si <= tx[i];
      @(posedge lclk) link_scl <= 1'b1;
      rx[i] = spi_so;
    end
  endtask

  // Two-wire idle is clock high
  task automatic i2c_idle();
    link_scl = 1'b1;
  endtask

  task automatic i2c_wait(input int n);
    repeat (n) @(posedge lclk);
  endtask

  // Eight bits then a released ninth; slow so the core oversamples
  task automatic i2c_byte(input logic [7:0] tx, output logic ack);
    logic [8:0] b;
    b = {tx, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      link_scl <= 1'b0;
      i2c_wait(4);
      sda_low <= !b[i];
      i2c_wait(4);
      link_scl <= 1'b1;
      i2c_wait(8);
      ack = !sda;
      i2c_rx = {i2c_rx[7:0], sda};
    end
  endtask

  // Start, address, sub-address, one data byte, stop
  task automatic i2c_write(input logic [7:0] a, s, d,
                           output logic [2:0] ak);
    sda_low <= 1'b1;
    i2c_wait(8);
    i2c_byte(a, ak[2]);
    i2c_byte(s, ak[1]);
    i2c_byte(d, ak[0]);
    i2c_stop();
  endtask

  // Stop: data rises while the clock stays high
  task automatic i2c_stop();
    link_scl <= 1'b0;
    i2c_wait(4);
    sda_low <= 1'b1;
    i2c_wait(4);
    link_scl <= 1'b1;
    i2c_wait(8);
    sda_low <= 1'b0;
    i2c_wait(8);
  endtask

  // Sub-address, repeated start, one byte read and nacked, stop
  task automatic i2c_read(input logic [7:0] a, s, output logic [7:0] d);
    logic ak;
    sda_low <= 1'b1;
    i2c_wait(8);
    i2c_byte(a, ak);
    i2c_byte(s, ak);
    link_scl <= 1'b0;
    i2c_wait(4);
    sda_low <= 1'b0;
    i2c_wait(4);
    link_scl <= 1'b1;
    i2c_wait(8);
    sda_low <= 1'b1;
    i2c_wait(8);
    i2c_byte(a | 8'h01, ak);
    i2c_byte(8'hff, ak);
    d = i2c_rx[8:1];
    i2c_stop();
  endtask
endmodule

// ==== testbench/srp_port_bench.sv ====
module srp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk, sys_rst, lclk, if_sel_i2c, strap, tx_fifo_full;
  logic        fifo_en, rs485_en, thr_full, tx_above_trig, tx_all_empty;
  logic        rx_avail, rx_above_trig, link_scl, spi_cs_n, spi_si;
  logic        spi_so, spi_so_oe, sda_low, i2c_sda_oe, reg_wr, reg_rd;
  logic        irq_tx_n, irq_rx_n, irq_n, tx, rx;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, r0, r1;
  logic [2:0]  acks;
  logic [11:0] wq[$];
  int          fails, check_count, rd_n;
  wire         sda = !(sda_low || i2c_sda_oe); // Pull-up wire

  // ==========================================================
  // Clocks: core 100 ns, link 125 ns at an unrelated phase
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;
  initial begin
    lclk = 1'b0;
    #37;
    forever #62.5 lclk = ~lclk;
  end

  // Core register file answer and capture of strobes
  assign reg_rdata = {4'hc, reg_addr};
  always @(negedge core_clk) begin
    if (reg_wr === 1'b1) wq.push_back({reg_addr, reg_wdata});
    if (reg_rd === 1'b1 && reg_addr === 4'h3) rd_n++;
  end

  srp_port dut_u (.core_clk, .sys_rst, .link_scl, .if_sel_i2c,
    .addr_strap_lo(strap), .addr_strap_hi(strap), .i2c_sda_i(sda),
    .i2c_sda_o(), .i2c_sda_oe, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_fifo_full,
    .fifo_en, .rs485_en, .thr_full, .tx_above_trig, .tx_all_empty,
    .rx_avail, .rx_above_trig, .irq_tx_n, .irq_rx_n, .irq_n);

  // A released data out reads as its inverse, so late enables show
  srp_host host_u (.lclk, .spi_so(spi_so_oe ? spi_so : !spi_so), .sda,
    .link_scl, .spi_cs_n, .spi_si, .sda_low);

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [11:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Bounded wait for captured writes
  task automatic wait_wq(input int n);
    for (int k = 0; k < 60 && wq.size() < n; k++) @(negedge core_clk);
    if (wq.size() < n) begin
      fails++;
      final_report();
    end
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {strap, if_sel_i2c, tx_fifo_full} = 3'h4;
    {fifo_en, rs485_en, thr_full, tx_above_trig} = 4'h0;
    {tx_all_empty, rx_avail, rx_above_trig} = 3'h0;
    do_reset();
    // Burst write of two bytes to register 5
    host_u.cs_lo();
    host_u.spi_byte(8'h28, r0);
    host_u.spi_byte(8'ha5, r0);
    host_u.spi_byte(8'h3c, r0);
    host_u.cs_hi();
    wait_wq(2);
    check("wr0", wq[0], 12'h5a5);
    check("wr1", wq[1], 12'h53c);
    // Nonzero channel field is dropped
    wq.delete();
    host_u.cs_lo();
    host_u.spi_byte(8'h2a, r0);
    host_u.spi_byte(8'h77, r0);
    host_u.cs_hi();
    repeat (40) @(negedge core_clk);
    check("chan", 12'(wq.size()), 12'h0);
    // Burst read of register 3, one prefetch beyond the last byte
    host_u.cs_lo();
    host_u.spi_byte(8'h98, r0);
    host_u.spi_byte(8'h00, r0);
    host_u.spi_byte(8'h00, r1);
    host_u.cs_hi();
    @(negedge core_clk);
    check("rd0", 12'(r0), 12'h0c3);
    check("rd1", 12'(r1), 12'h0c3);
    check("rd_n", 12'(rd_n), 12'h3);
    check("so_oe", 12'(spi_so_oe), 12'h000);
    // Two strap ties; the second writes into a full TX FIFO
    for (int k = 0; k < 2; k++) begin
      @(negedge core_clk);
      host_u.i2c_idle();
      if_sel_i2c = 1'b1;
      strap = (k == 0);
      tx_fifo_full = (k == 1);
      do_reset();
      wq.delete();
      host_u.i2c_write(k ? 8'h6a : 8'h60, k ? 8'h00 : 8'h10, 8'ha3, acks);
      check("acks", 12'(acks), k ? 12'h006 : 12'h007);
      wait_wq(1);
      check("i2c_wr", wq[0], k ? 12'h0a3 : 12'h2a3);
    end
    // Address of the other strap tie is ignored
    host_u.i2c_write(8'h60, 8'h10, 8'h55, acks);
    check("nack", 12'(acks), 12'h000);
    check("no_wr", 12'(wq.size()), 12'h1);
    // Register 3 read through a repeated start; the nack fetches nothing
    host_u.i2c_read(8'h6a, 8'h18, r0);
    check("i2c_rd", 12'(r0), 12'h0c3);
    check("rd_n2", 12'(rd_n), 12'h004);
    // Every combination of the interrupt sources
    @(negedge core_clk);
    for (int i = 0; i < 128; i++) begin
      {fifo_en, rs485_en, thr_full, tx_above_trig, tx_all_empty,
       rx_avail, rx_above_trig} = 7'(i);
      tx = rs485_en ? !tx_all_empty && !(fifo_en && !tx_above_trig)
                    : (fifo_en ? tx_above_trig : thr_full);
      rx = fifo_en ? !rx_above_trig : !rx_avail;
      repeat (2) @(negedge core_clk);
      check("irq_tx_n", 12'(irq_tx_n), 12'(tx));
      check("irq_rx_n", 12'(irq_rx_n), 12'(rx));
    end
    // One-cycle reset in mid-run with the interrupt asserted
    sys_rst = 1'b1;
    @(negedge core_clk);
    check("rst", 12'({irq_n, reg_wr, i2c_sda_oe}), 12'h004);
    sys_rst = 1'b0;
    repeat (2) @(negedge core_clk);
    check("rst_rel", 12'(irq_n), 12'h000);
    final_report();
  end
endmodule
